// *** rtc_defs.svh ***
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
// Functional notes
// - Wrap event enable high requests an interrupt when the count wraps to zero.
// - Match flag, event bit 1, sets when the count equals the match value.
// - Wrap flag, event bit 0, sets when the count reaches the limit and wraps.
// - Writing one to an event flag clears it; writing zero leaves it.
// - One shared 8-bit staging byte serves every 16-bit register.
// - Run-while-halted low freezes the counter during CPU debug halt.
// - Source select picks full rate, slow rate, crystal pin or external pin.
// - Count is 16 bits, resets to zero, low byte first.
// - Count writes apply after two slow clock cycles.
// - Limit resets to all ones and applies after two slow cycles, counting or stopped.
// - Match value is 16-bit read/write, resets to zero, low byte first.
// - Tick interval field 6:3 gives 4 to 32768 slow cycles; zero none.
// - Tick setup bit 0 enables the periodic tick timer.
// - Tick status bit 0 reads one while tick setup is still synchronizing.
// - Match event enable bit 1 requests an interrupt on each match.
// - Tick flag sets on each periodic tick and clears on a written one.
// - Prescaler field divides the slow clock by two to its power.
// - Counter enable bit starts the counter; zero keeps it stopped.

// ----------------------------------------
// Register map
// ----------------------------------------
`define RTC_AW            5
`define RTC_A_CTRL        5'h00
`define RTC_A_STAT        5'h01
`define RTC_A_IEN         5'h02
`define RTC_A_FLAGS       5'h03
`define RTC_A_STAGE       5'h04
`define RTC_A_HALT        5'h05
`define RTC_A_SRC         5'h07
`define RTC_A_COUNT_L     5'h08
`define RTC_A_COUNT_H     5'h09
`define RTC_A_LIMIT_L     5'h0A
`define RTC_A_LIMIT_H     5'h0B
`define RTC_A_MATCH_L     5'h0C
`define RTC_A_MATCH_H     5'h0D
`define RTC_A_TSET        5'h10
`define RTC_A_TSTAT       5'h11
`define RTC_A_TIEN        5'h12
`define RTC_A_TFLAG       5'h13

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RTC_BIT_WRAP      0
`define RTC_BIT_MATCH     1
`define RTC_BIT_ENABLE    0
`define RTC_BIT_CBUSY     1
`define RTC_BIT_LBUSY     2
`define RTC_BIT_TBUSY     0
`define RTC_BIT_TICK      0
`define RTC_BIT_HRUN      0
`define RTC_FLD_LO        3
`define RTC_FLD_HI        6

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define RTC_RST_COUNT     16'h0000
`define RTC_RST_LIMIT     16'hFFFF
`define RTC_RST_MATCH     16'h0000
`define RTC_SRC_FULL      2'h0
`define RTC_SRC_SLOW      2'h1
`define RTC_SRC_XTAL      2'h2
`define RTC_SRC_EXT       2'h3
`define RTC_ULP_DIV_LAST  5'h1F
`define RTC_IVAL_OFF      4'h0
`define RTC_IVAL_RSV      4'hF
`endif

// *** rtc_pkg.sv ***
`include "rtc_defs.svh"
package rtc_pkg;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SY_IDLE  = 2'h0,
    SY_WAIT1 = 2'h1,
    SY_WAIT2 = 2'h3
  } rtc_sync_t;

  typedef struct packed {
    logic                wr;
    logic                rd;
    logic [`RTC_AW-1:0]  addr;
    logic [7:0]          wdata;
  } rtc_bus_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [4:0] div;
    logic       en;
  } rtc_src_t;

  typedef struct packed {
    logic [14:0] div;
    logic        pre_en;
    logic        tick;
  } rtc_psc_t;

  typedef struct packed {
    logic        counter_enable;
    logic [3:0]  prescale;
    logic [1:0]  event_en;
    logic [1:0]  flags;
    logic [7:0]  stage;
    logic        run_while_halted;
    logic [1:0]  source;
    logic [15:0] count;
    logic [15:0] limit;
    logic [15:0] match;
    logic        tick_enable;
    logic [3:0]  tick_ival;
    logic        tick_ien;
    logic        tick_flag;
    rtc_sync_t   cnt_sy;
    rtc_sync_t   lim_sy;
    rtc_sync_t   tset_sy;
    logic [15:0] cnt_shadow;
    logic [15:0] lim_shadow;
    logic [4:0]  tset_shadow;
    logic [7:0]  rdata;
  } rtc_core_t;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Advance one write synchronizer by a slow clock edge
  function automatic rtc_sync_t rtc_sync_step(input rtc_sync_t st, input logic wr,
                                              input logic slow);
    rtc_sync_t n;
    n = st;
    unique case (st)
      SY_IDLE:  n = wr ? SY_WAIT1 : SY_IDLE;
      SY_WAIT1: n = wr ? SY_WAIT1 : (slow ? SY_WAIT2 : SY_WAIT1);
      SY_WAIT2: n = wr ? SY_WAIT1 : (slow ? SY_IDLE : SY_WAIT2);
      default:  n = SY_IDLE;
    endcase
    return n;
  endfunction

  // Mask of the n low bits of the slow divider
  function automatic logic [14:0] rtc_low_mask(input logic [3:0] n);
    logic [15:0] m;
    m = (16'h0001 << n) - 16'h0001;
    return m[14:0];
  endfunction
endpackage

// *** rtc_src_sel.sv ***
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_src_sel (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Source pins, asynchronous
  input  wire logic        i_ulp_clk,
  input  wire logic        i_crystal_pin,
  input  wire logic        i_ext_pin,
  // Selection and slow enable
  input  wire logic [1:0]  i_source,
  output logic             o_slow_en
);
  import rtc_pkg::*;

  rtc_src_t   st;
  rtc_src_t   nx;
  logic [2:0] rise;

  // Rising edges seen after the two-stage synchronizers
  assign rise = st.s2 & ~st.s3;

  // Synchronize pins, derive slow rate, pick the source
  always_comb begin
    nx = st;
    nx.s1 = {i_ext_pin, i_crystal_pin, i_ulp_clk};
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    if (rise[0]) begin
      nx.div = 5'(st.div + 5'h01);
    end
    unique case (i_source)
      `RTC_SRC_FULL: nx.en = rise[0];
      `RTC_SRC_SLOW: nx.en = rise[0] && (st.div == `RTC_ULP_DIV_LAST);
      `RTC_SRC_XTAL: nx.en = rise[1];
      `RTC_SRC_EXT:  nx.en = rise[2];
    endcase
    if (!i_rstn) begin
      nx = '0;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    st <= nx;
  end

  assign o_slow_en = st.en;
endmodule // rtc_src_sel

// *** rtc_prescale.sv ***
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_prescale (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Slow enable, already frozen in halt
  input  wire logic        i_slow_en,
  // Settings
  input  wire logic [3:0]  i_prescale,
  input  wire logic        i_tick_enable,
  input  wire logic [3:0]  i_tick_ival,
  // Enables out
  output logic             o_pre_en,
  output logic             o_tick
);
  import rtc_pkg::*;

  rtc_psc_t    st;
  rtc_psc_t    nx;
  logic [14:0] pmask;
  logic [14:0] tmask;

  // Divider taps for the prescaler and the tick interval
  assign pmask = rtc_low_mask(i_prescale);
  assign tmask = rtc_low_mask(4'(i_tick_ival + 4'h1));

  // Shared slow divider with two taps
  always_comb begin
    nx = st;
    nx.pre_en = 1'b0;
    nx.tick = 1'b0;
    if (i_slow_en) begin
      nx.div = 15'(st.div + 15'h0001);
      nx.pre_en = ((st.div & pmask) == pmask);
      nx.tick = i_tick_enable
                && (i_tick_ival != `RTC_IVAL_OFF)
                && (i_tick_ival != `RTC_IVAL_RSV)
                && ((st.div & tmask) == tmask);
    end
    if (!i_rstn) begin
      nx = '0;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    st <= nx;
  end

  assign o_pre_en = st.pre_en;
  assign o_tick = st.tick;
endmodule // rtc_prescale

// *** rtc_counter_top.sv ***
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_counter_top (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  // Register port
  input  wire rtc_pkg::rtc_bus_t  i_bus,
  output logic [7:0]              o_rdata,
  // Debug halt from the CPU
  input  wire logic               i_cpu_halted,
  // Slow clock source pins
  input  wire logic               i_ulp_clk,
  input  wire logic               i_crystal_pin,
  input  wire logic               i_ext_pin,
  // Interrupt requests
  output logic                    o_wrap_irq,
  output logic                    o_match_irq,
  output logic                    o_tick_irq
);
  import rtc_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  rtc_core_t   st;
  rtc_core_t   nx;
  logic        slow_en;
  logic        pre_en;
  logic        tick_ev;
  logic        freeze;
  logic        step;
  logic        wrap_set;
  logic        match_hit;
  logic [15:0] count_step;
  logic        cnt_wr;
  logic        lim_wr;
  logic        tset_wr;
  logic        cnt_apply;
  logic        lim_apply;
  logic        tset_apply;
  logic        wr_flags;
  logic        wr_tflag;

  // ----------------------------------------
  // Slow clock and dividers
  // ----------------------------------------
  rtc_src_sel u_src (
    .i_clk         (i_clk),
    .i_rstn        (i_rstn),
    .i_ulp_clk     (i_ulp_clk),
    .i_crystal_pin (i_crystal_pin),
    .i_ext_pin     (i_ext_pin),
    .i_source      (st.source),
    .o_slow_en     (slow_en)
  );

  rtc_prescale u_psc (
    .i_clk         (i_clk),
    .i_rstn        (i_rstn),
    .i_slow_en     (slow_en && !freeze),
    .i_prescale    (st.prescale),
    .i_tick_enable (st.tick_enable),
    .i_tick_ival   (st.tick_ival),
    .o_pre_en      (pre_en),
    .o_tick        (tick_ev)
  );

  // ----------------------------------------
  // Strobes and counting terms
  // ----------------------------------------
  // Debug halt freezes the prescale and tick divider and counting unless run-while-halted is set; synchronized writes still land
  assign freeze = i_cpu_halted && !st.run_while_halted;

  // Committing writes to synchronized registers and to the flag registers
  assign cnt_wr   = i_bus.wr && (i_bus.addr == `RTC_A_COUNT_H);
  assign lim_wr   = i_bus.wr && (i_bus.addr == `RTC_A_LIMIT_H);
  assign tset_wr  = i_bus.wr && (i_bus.addr == `RTC_A_TSET);
  assign wr_flags = i_bus.wr && (i_bus.addr == `RTC_A_FLAGS);
  assign wr_tflag = i_bus.wr && (i_bus.addr == `RTC_A_TFLAG);

  // A value lands on the second slow edge after its write
  assign cnt_apply  = (st.cnt_sy == SY_WAIT2) && slow_en && !cnt_wr;
  assign lim_apply  = (st.lim_sy == SY_WAIT2) && slow_en && !lim_wr;
  assign tset_apply = (st.tset_sy == SY_WAIT2) && slow_en && !tset_wr;

  // Counter step, wrap and match detection
  assign step       = pre_en && st.counter_enable && !freeze && !cnt_apply;
  assign wrap_set   = step && (st.count == st.limit);
  assign count_step = wrap_set ? `RTC_RST_COUNT : 16'(st.count + 16'h0001);
  assign match_hit  = step && (count_step == st.match);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nx = st;
    nx.rdata = 8'h00;

    // Register reads, data stand for one cycle
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        `RTC_A_CTRL:    nx.rdata = {1'h0, st.prescale, 2'h0, st.counter_enable};
        `RTC_A_STAT:    nx.rdata = {5'h00, st.lim_sy != SY_IDLE,
                                    st.cnt_sy != SY_IDLE, 1'h0};
        `RTC_A_IEN:     nx.rdata = {6'h00, st.event_en};
        `RTC_A_FLAGS:   nx.rdata = {6'h00, st.flags};
        `RTC_A_STAGE:   nx.rdata = st.stage;
        `RTC_A_HALT:    nx.rdata = {7'h00, st.run_while_halted};
        `RTC_A_SRC:     nx.rdata = {6'h00, st.source};
        `RTC_A_COUNT_L: begin
          nx.rdata = st.count[7:0];
          nx.stage = st.count[15:8];
        end
        `RTC_A_LIMIT_L: begin
          nx.rdata = st.limit[7:0];
          nx.stage = st.limit[15:8];
        end
        `RTC_A_MATCH_L: begin
          nx.rdata = st.match[7:0];
          nx.stage = st.match[15:8];
        end
        `RTC_A_COUNT_H,
        `RTC_A_LIMIT_H,
        `RTC_A_MATCH_H: nx.rdata = st.stage;
        `RTC_A_TSET:    nx.rdata = {1'h0, st.tick_ival, 2'h0, st.tick_enable};
        `RTC_A_TSTAT:   nx.rdata = {7'h00, st.tset_sy != SY_IDLE};
        `RTC_A_TIEN:    nx.rdata = {7'h00, st.tick_ien};
        `RTC_A_TFLAG:   nx.rdata = {7'h00, st.tick_flag};
        default:        nx.rdata = 8'h00;
      endcase
    end

    // Register writes; low bytes park in the staging byte
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        `RTC_A_CTRL: begin
          nx.counter_enable = i_bus.wdata[`RTC_BIT_ENABLE];
          nx.prescale = i_bus.wdata[`RTC_FLD_HI:`RTC_FLD_LO];
        end
        `RTC_A_IEN:     nx.event_en = i_bus.wdata[`RTC_BIT_MATCH:`RTC_BIT_WRAP];
        `RTC_A_HALT:    nx.run_while_halted = i_bus.wdata[`RTC_BIT_HRUN];
        `RTC_A_SRC:     nx.source = i_bus.wdata[1:0];
        `RTC_A_STAGE,
        `RTC_A_COUNT_L,
        `RTC_A_LIMIT_L,
        `RTC_A_MATCH_L: nx.stage = i_bus.wdata;
        `RTC_A_COUNT_H: nx.cnt_shadow = {i_bus.wdata, st.stage};
        `RTC_A_LIMIT_H: nx.lim_shadow = {i_bus.wdata, st.stage};
        `RTC_A_MATCH_H: nx.match = {i_bus.wdata, st.stage};
        `RTC_A_TSET:    nx.tset_shadow = {i_bus.wdata[`RTC_FLD_HI:`RTC_FLD_LO],
                                          i_bus.wdata[`RTC_BIT_TICK]};
        `RTC_A_TIEN:    nx.tick_ien = i_bus.wdata[`RTC_BIT_TICK];
        default: begin
        end
      endcase
    end

    // Write synchronizers toward the slow domain
    nx.cnt_sy  = rtc_sync_step(st.cnt_sy, cnt_wr, slow_en);
    nx.lim_sy  = rtc_sync_step(st.lim_sy, lim_wr, slow_en);
    nx.tset_sy = rtc_sync_step(st.tset_sy, tset_wr, slow_en);
    if (lim_apply) begin
      nx.limit = st.lim_shadow;
    end
    if (tset_apply) begin
      nx.tick_ival = st.tset_shadow[4:1];
      nx.tick_enable = st.tset_shadow[0];
    end

    // Counter: a landing write beats a step
    if (cnt_apply) begin
      nx.count = st.cnt_shadow;
    end else if (step) begin
      nx.count = count_step;
    end

    // Event flags: write one clears, a new event wins
    nx.flags = st.flags & ~(wr_flags ? i_bus.wdata[1:0] : 2'h0);
    if (wrap_set) begin
      nx.flags[`RTC_BIT_WRAP] = 1'b1;
    end
    if (match_hit) begin
      nx.flags[`RTC_BIT_MATCH] = 1'b1;
    end
    nx.tick_flag = (st.tick_flag && !(wr_tflag && i_bus.wdata[`RTC_BIT_TICK]))
                   || tick_ev;

    // Synchronous reset values
    if (!i_rstn) begin
      nx = '0;
      nx.count = `RTC_RST_COUNT;
      nx.limit = `RTC_RST_LIMIT;
      nx.match = `RTC_RST_MATCH;
      nx.lim_shadow = `RTC_RST_LIMIT;
      nx.cnt_sy = SY_IDLE;
      nx.lim_sy = SY_IDLE;
      nx.tset_sy = SY_IDLE;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    st <= nx;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_rdata     = st.rdata;
  assign o_wrap_irq  = st.flags[`RTC_BIT_WRAP] && st.event_en[`RTC_BIT_WRAP];
  assign o_match_irq = st.flags[`RTC_BIT_MATCH] && st.event_en[`RTC_BIT_MATCH];
  assign o_tick_irq  = st.tick_flag && st.tick_ien;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_wrap_flag_set : assert property (
    wrap_set |=> st.flags[`RTC_BIT_WRAP])
    else $error("wrap flag not set on wrap");

  a_wrap_to_zero : assert property (
    wrap_set && !cnt_apply |=> st.count == `RTC_RST_COUNT)
    else $error("count did not wrap to zero");

  a_count_step_up : assert property (
    step && !wrap_set && !cnt_apply |=> st.count == 16'($past(st.count) + 16'h0001))
    else $error("count did not advance by one");

  a_match_flag_set : assert property (
    match_hit |=> st.flags[`RTC_BIT_MATCH] && st.count == st.match)
    else $error("match flag or count wrong after match");

  a_flag_w1c : assert property (
    wr_flags && i_bus.wdata[`RTC_BIT_WRAP] && !wrap_set |=> !st.flags[`RTC_BIT_WRAP])
    else $error("wrap flag not cleared by write of one");

  a_wrap_irq_req : assert property (
    $rose(st.flags[`RTC_BIT_WRAP]) && st.event_en[`RTC_BIT_WRAP] |-> o_wrap_irq)
    else $error("wrap interrupt not requested");

  a_match_irq_req : assert property (
    $rose(st.flags[`RTC_BIT_MATCH]) && st.event_en[`RTC_BIT_MATCH] |-> o_match_irq)
    else $error("match interrupt not requested");

  a_count_sync_land : assert property (
    cnt_apply |=> st.cnt_sy == SY_IDLE && st.count == $past(st.cnt_shadow))
    else $error("count write did not land");

  a_busy_on_write : assert property (
    cnt_wr |=> st.cnt_sy == SY_WAIT1 ##1 st.cnt_sy != SY_IDLE)
    else $error("count busy not raised by write");

  a_halt_freeze : assert property (
    freeze && !cnt_apply |=> $stable(st.count))
    else $error("count moved while halted");

  a_stage_capture : assert property (
    i_bus.rd && i_bus.addr == `RTC_A_COUNT_L |=> st.stage == $past(st.count[15:8]))
    else $error("high byte not staged on low read");

  a_tick_flag_set : assert property (
    tick_ev |=> st.tick_flag)
    else $error("tick flag not set");

  a_reset_values : assert property (
    disable iff (1'b0) !i_rstn |=> st.count == `RTC_RST_COUNT && st.limit == `RTC_RST_LIMIT)
    else $error("count or limit wrong after reset");

  a_reset_match : assert property (
    disable iff (1'b0) !i_rstn |=> st.match == `RTC_RST_MATCH && st.flags == 2'h0)
    else $error("match or flags wrong after reset");

  a_limit_sync_land : assert property (
    lim_apply |=> st.lim_sy == SY_IDLE && st.limit == $past(st.lim_shadow))
    else $error("limit write did not land");

  a_limit_busy_wr : assert property (
    lim_wr |=> st.lim_sy == SY_WAIT1)
    else $error("limit busy not raised by write");

  a_tick_sync_land : assert property (
    tset_apply |=> st.tset_sy == SY_IDLE && st.tick_enable == $past(st.tset_shadow[0]))
    else $error("tick setup write did not land");

  a_tick_busy_wr : assert property (
    tset_wr |=> st.tset_sy == SY_WAIT1)
    else $error("tick setup busy not raised by write");

  a_count_early_hold : assert property (
    st.cnt_sy == SY_WAIT1 && !step |=> $stable(st.count))
    else $error("count write landed too early");

  a_match_write : assert property (
    i_bus.wr && i_bus.addr == `RTC_A_MATCH_H |=> st.match == {$past(i_bus.wdata), $past(st.stage)})
    else $error("match value not committed from staging");

  a_stage_write : assert property (
    i_bus.wr && i_bus.addr == `RTC_A_COUNT_L |=> st.stage == $past(i_bus.wdata))
    else $error("low byte write not staged");

  a_flag_zero_keep : assert property (
    wr_flags && !i_bus.wdata[`RTC_BIT_MATCH] && st.flags[`RTC_BIT_MATCH]
    |=> st.flags[`RTC_BIT_MATCH])
    else $error("match flag cleared by write of zero");

  a_enable_off_hold : assert property (
    !st.counter_enable && !cnt_apply |=> $stable(st.count))
    else $error("count moved while disabled");

  a_tick_gated : assert property (
    tick_ev |-> $past(st.tick_enable))
    else $error("tick issued while timer disabled");

  a_tick_ival_valid : assert property (
    tick_ev |-> $past(st.tick_ival) != `RTC_IVAL_OFF && $past(st.tick_ival) != `RTC_IVAL_RSV)
    else $error("tick issued with interval off or reserved");

  a_wrap_count_zero : assert property (
    $rose(st.flags[`RTC_BIT_WRAP]) |-> st.count == `RTC_RST_COUNT)
    else $error("wrap flag rose without count at zero");

  a_halt_no_event : assert property (
    freeze |=> !$rose(st.flags[`RTC_BIT_WRAP]) && !$rose(st.flags[`RTC_BIT_MATCH]))
    else $error("event raised while halted");

  a_halt_no_tick : assert property (
    freeze |=> !tick_ev)
    else $error("tick issued while halted");

  a_tick_flag_clear : assert property (
    wr_tflag && i_bus.wdata[`RTC_BIT_TICK] && !tick_ev |=> !st.tick_flag)
    else $error("tick flag not cleared by write of one");

  c_wrap_seen   : cover property (wrap_set && st.event_en[`RTC_BIT_WRAP]);
  c_match_seen  : cover property (match_hit);
  c_count_land  : cover property (cnt_wr ##[1:200] cnt_apply);
  c_tick_seen   : cover property (tick_ev && st.tick_ien);
  c_halt_seen   : cover property (freeze && st.counter_enable);
endmodule // rtc_counter_top

// *** rtc_top_end.sv ***
`timescale 1ns/1ps

// *** rtc_counter_with_tick_timer_tb.sv ***
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_counter_with_tick_timer_tb;
  import rtc_pkg::*;
  `define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp=%h got=%h", nm, e, g); end end

  logic       i_clk;
  logic       i_rstn;
  logic       i_cpu_halted;
  logic       ulp = 1'b0;
  logic       xtal = 1'b0;
  logic       ext = 1'b0;
  rtc_bus_t   bus;
  logic [7:0] rdata;
  logic       wrap_irq;
  logic       match_irq;
  logic       tick_irq;
  logic       rd_q = 1'b0;
  logic [15:0] q_exp[$];
  logic [7:0] v;
  logic [31:0] r;
  int         n_fail;
  int         comparisons;
  int         cyc;
  int         seed;
  int         t0;
  int         s_src[5] = '{0, 1, 2, 3, 0};
  int         s_psc[5] = '{0, 0, 0, 0, 2};
  int         s_exp[5] = '{64, 2, 80, 53, 16};
  logic [7:0] t_off[3] = '{8'h01, 8'h79, 8'h08};

  // ----------------------------------------
  // Clock, source pins and design
  // ----------------------------------------
  // Free running bus clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // Source pins at 20, 16 and 24 bus cycles per period
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc % 10 == 0) ulp <= ~ulp;
    if (cyc % 8 == 3) xtal <= ~xtal;
    if (cyc % 12 == 5) ext <= ~ext;
  end

  rtc_counter_top dut_u (
    .i_clk         (i_clk),
    .i_rstn        (i_rstn),
    .i_bus         (bus),
    .o_rdata       (rdata),
    .i_cpu_halted  (i_cpu_halted),
    .i_ulp_clk     (ulp),
    .i_crystal_pin (xtal),
    .i_ext_pin     (ext),
    .o_wrap_irq    (wrap_irq),
    .o_match_irq   (match_irq),
    .o_tick_irq    (tick_irq)
  );

  // Read data stands only in the cycle after the strobe; check it there
  always @(posedge i_clk) begin
    if (rd_q && q_exp.size() > 0) begin
      `CHK("rdata", q_exp[0][7:0], rdata & q_exp[0][15:8])
      void'(q_exp.pop_front());
    end
    rd_q <= bus.rd & i_rstn;
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic op(input logic w, input logic [`RTC_AW-1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_clk);
    bus <= '0;
  endtask

  task automatic wr(input logic [`RTC_AW-1:0] a, input logic [7:0] d);
    op(1'b1, a, d);
  endtask

  task automatic w16(input logic [`RTC_AW-1:0] a, input logic [15:0] d);
    op(1'b1, a, d[7:0]);
    op(1'b1, a + 5'h01, d[15:8]);
  endtask

  // Read, then note the expectation with its mask
  task automatic rd_exp(input logic [`RTC_AW-1:0] a, input logic [7:0] e,
                        input logic [7:0] m = 8'hFF);
    op(1'b0, a, 8'h00);
    q_exp.push_back({m, e & m});
  endtask

  task automatic rd16(input logic [`RTC_AW-1:0] a, input logic [15:0] e);
    rd_exp(a, e[7:0]);
    rd_exp(a + 5'h01, e[15:8]);
  endtask

  task automatic rd_get(input logic [`RTC_AW-1:0] a, output logic [7:0] d);
    op(1'b0, a, 8'h00);
    @(posedge i_clk);
    d = rdata;
  endtask

  // Bounded poll of one status bit
  task automatic poll(input logic [`RTC_AW-1:0] a, input int b, input logic lvl);
    logic [7:0] d;
    for (int i = 0; i < 2000; i++) begin
      rd_get(a, d);
      if (d[b] === lvl) return;
    end
    n_fail++;
    $display("[FAIL] poll %h bit %0d exp=%h got=%h", a, b, lvl, d[b]);
    test_done();
  endtask

  task automatic wait_tick;
    for (int i = 0; i < 5000; i++) begin
      @(posedge i_clk);
      if (tick_irq === 1'b1) return;
    end
    n_fail++;
    $display("[FAIL] tick_irq exp=1 got=0");
    test_done();
  endtask

  task automatic test_done;
    $display("mismatches=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    i_rstn = 1'b0;
    i_cpu_halted = 1'b0;
    bus = '0;
    n_fail = 0;
    comparisons = 0;
    seed = 32'hE2A2;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    // Reset values and an unmapped hole
    rd_exp(`RTC_A_FLAGS, 8'h00);
    rd16(`RTC_A_COUNT_L, 16'h0000);
    rd16(`RTC_A_LIMIT_L, 16'hFFFF);
    rd16(`RTC_A_MATCH_L, 16'h0000);
    rd_exp(`RTC_A_TSTAT, 8'h00);
    rd_exp(5'h06, 8'h00);
    // Staging byte and byte pairing with random values
    repeat (3) begin
      r = $random(seed);
      wr(`RTC_A_STAGE, r[23:16]);
      rd_exp(`RTC_A_STAGE, r[23:16]);
      wr(`RTC_A_MATCH_L, r[7:0]);
      rd_exp(`RTC_A_STAGE, r[7:0]);
      wr(`RTC_A_MATCH_H, r[15:8]);
      rd16(`RTC_A_MATCH_L, r[15:0]);
      rd_exp(`RTC_A_MATCH_H, r[15:8]);
    end
    // Count write goes through the slow domain
    w16(`RTC_A_COUNT_L, 16'h1234);
    rd_exp(`RTC_A_STAT, 8'h02, 8'h02);
    rd16(`RTC_A_COUNT_L, 16'h0000);
    poll(`RTC_A_STAT, 1, 1'b0);
    rd16(`RTC_A_COUNT_L, 16'h1234);
    w16(`RTC_A_COUNT_L, 16'h0000);
    poll(`RTC_A_STAT, 1, 1'b0);
    // Short wrap limit with a match below it
    w16(`RTC_A_LIMIT_L, 16'h0005);
    rd_exp(`RTC_A_STAT, 8'h04, 8'h04);
    poll(`RTC_A_STAT, 2, 1'b0);
    rd16(`RTC_A_LIMIT_L, 16'h0005);
    w16(`RTC_A_MATCH_L, 16'h0003);
    wr(`RTC_A_IEN, 8'h03);
    rd_exp(`RTC_A_IEN, 8'h03);
    rd_exp(`RTC_A_FLAGS, 8'h00);
    wr(`RTC_A_CTRL, 8'h01);
    poll(`RTC_A_FLAGS, 0, 1'b1);
    `CHK("wrap_irq", 1'b1, wrap_irq)
    `CHK("match_irq", 1'b1, match_irq)
    wr(`RTC_A_CTRL, 8'h00);
    rd_exp(`RTC_A_FLAGS, 8'h03);
    wr(`RTC_A_IEN, 8'h00);
    repeat (2) @(posedge i_clk);
    `CHK("wrap_irq off", 1'b0, wrap_irq)
    wr(`RTC_A_FLAGS, 8'h00);
    rd_exp(`RTC_A_FLAGS, 8'h03);
    wr(`RTC_A_FLAGS, 8'h01);
    rd_exp(`RTC_A_FLAGS, 8'h02);
    wr(`RTC_A_FLAGS, 8'h02);
    rd_exp(`RTC_A_FLAGS, 8'h00);
    // Debug halt freezes the counter unless told to run
    i_cpu_halted <= 1'b1;
    wr(`RTC_A_CTRL, 8'h01);
    rd_exp(`RTC_A_CTRL, 8'h01);
    w16(`RTC_A_COUNT_L, 16'h0004);
    poll(`RTC_A_STAT, 1, 1'b0);
    repeat (200) @(posedge i_clk);
    rd16(`RTC_A_COUNT_L, 16'h0004);
    wr(`RTC_A_HALT, 8'h01);
    rd_exp(`RTC_A_HALT, 8'h01);
    repeat (60) @(posedge i_clk);
    rd_get(`RTC_A_COUNT_L, v);
    `CHK("count runs", 1'b1, v !== 8'h04)
    i_cpu_halted <= 1'b0;
    wr(`RTC_A_CTRL, 8'h00);
    w16(`RTC_A_LIMIT_L, 16'hFFFF);
    poll(`RTC_A_STAT, 2, 1'b0);
    // Each source and a prescaler over a fixed window
    for (int k = 0; k < 5; k++) begin
      wr(`RTC_A_SRC, 8'(s_src[k]));
      rd_exp(`RTC_A_SRC, 8'(s_src[k]));
      w16(`RTC_A_COUNT_L, 16'h0000);
      poll(`RTC_A_STAT, 1, 1'b0);
      wr(`RTC_A_CTRL, 8'(s_psc[k] << 3) | 8'h01);
      repeat (1280) @(posedge i_clk);
      wr(`RTC_A_CTRL, 8'h00);
      rd_get(`RTC_A_COUNT_L, v);
      `CHK("count rate", 1'b1, (v + 2 >= s_exp[k]) && (v <= s_exp[k] + 2))
    end
    wr(`RTC_A_SRC, 8'h00);
    // Tick intervals measured between flag raises
    wr(`RTC_A_TIEN, 8'h01);
    for (int p = 1; p <= 3; p++) begin
      wr(`RTC_A_TSET, 8'(p << 3) | 8'h01);
      rd_exp(`RTC_A_TSTAT, 8'h01);
      poll(`RTC_A_TSTAT, 0, 1'b0);
      rd_exp(`RTC_A_TSET, 8'(p << 3) | 8'h01);
      wr(`RTC_A_TFLAG, 8'h01);
      wait_tick();
      t0 = cyc;
      wr(`RTC_A_TFLAG, 8'h01);
      rd_exp(`RTC_A_TFLAG, 8'h00);
      wait_tick();
      `CHK("tick gap", 1'b1, (cyc - t0 + 3 >= (20 << (p + 1))) &&
           (cyc - t0 <= (20 << (p + 1)) + 3))
    end
    // Interval off, reserved interval and timer disabled give no tick
    for (int k = 0; k < 3; k++) begin
      wr(`RTC_A_TSET, t_off[k]);
      poll(`RTC_A_TSTAT, 0, 1'b0);
      wr(`RTC_A_TFLAG, 8'h01);
      repeat (400) @(posedge i_clk);
      rd_exp(`RTC_A_TFLAG, 8'h00);
    end
    repeat (2) @(posedge i_clk);
    test_done();
  end
endmodule // rtc_counter_with_tick_timer_tb
